// >>> ccl_pkg.sv
package ccl_pkg;
   // Register map (8-bit control, system options and state registers, one aligned APB word each)
   localparam logic [7:0] CCL_OFS_CTRL = 8'h00;
   localparam logic [7:0] CCL_OFS_SYSOPT = 8'h04;
   localparam logic [7:0] CCL_OFS_STATE = 8'h08;
   // Control register fields
   localparam int CCL_BIT_ENABLE = 7;
   localparam int CCL_BIT_REFSEL = 6;
   localparam int CCL_BIT_FLAG = 5;
   localparam int CCL_BIT_IRQEN = 4;
   localparam int CCL_BIT_OUTLVL = 3;
   localparam int CCL_BIT_PINEN = 2;
   localparam int CCL_BIT_MODE_HI = 1;
   localparam int CCL_BIT_MODE_LO = 0;
   // System options fields
   localparam int CCL_BIT_ROUTE = 0;
   // Reset values
   localparam logic [7:0] CCL_CTRL_RST = 8'h00;
   localparam logic CCL_ROUTE_RST = 1'b0;
   // Edge mode codes
   localparam logic [1:0] CCL_MODE_FALL0 = 2'h0;
   localparam logic [1:0] CCL_MODE_RISE = 2'h1;
   localparam logic [1:0] CCL_MODE_FALL2 = 2'h2;
   localparam logic [1:0] CCL_MODE_BOTH = 2'h3;
   typedef enum logic [1:0] {
      CCL_PWR_RUN,
      CCL_PWR_WAIT,
      CCL_PWR_STOP_SHALLOW,
      CCL_PWR_STOP_DEEP
   } ccl_pwr_t;
endpackage : ccl_pkg

// >>> ccl_edge_if.sv
`timescale 1ns/10ps
interface ccl_edge_if;
   logic active;
   logic [1:0] mode;
   logic raw_level;
   logic level;
   logic event_pulse;
   modport ctrl (output active, output mode, output raw_level, input level, input event_pulse);
   modport det (input active, input mode, input raw_level, output level, output event_pulse);
endinterface : ccl_edge_if

// >>> ccl_edge_detect.sv
`timescale 1ns/10ps
module ccl_edge_detect
   import ccl_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link to control logic
   ccl_edge_if.det eif
);
   import ccl_pkg::*;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic last;
   } ccl_edge_state_t;

   ccl_edge_state_t st_reg;
   ccl_edge_state_t st_next;
   logic rise;
   logic fall;

   always_comb begin
      st_next = st_reg;
      st_next.sync1 = eif.raw_level;
      st_next.sync2 = st_reg.sync1;
      // Level is held at zero while the module is off
      st_next.last = eif.active ? st_reg.sync2 : 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign eif.level = st_reg.last;
   assign rise = eif.active && st_reg.sync2 && !st_reg.last;
   assign fall = eif.active && !st_reg.sync2 && st_reg.last;

   always_comb begin
      unique case (eif.mode)
         CCL_MODE_RISE: eif.event_pulse = rise;
         CCL_MODE_BOTH: eif.event_pulse = rise || fall;
         default: eif.event_pulse = fall;
      endcase
   end

   // A new high level at the chain end must be reported in rise mode
   a_edge_rise_evt: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(st_reg.sync2) && eif.active && eif.mode == CCL_MODE_RISE |-> eif.event_pulse)
      else $error("rising edge not reported");
endmodule : ccl_edge_detect

// >>> ccl_comparator_ctrl.sv
`timescale 1ns/10ps
// Function
// - Control bit 7 switches the whole comparator module on or off.
// - Bit 6 picks external positive pin (0) or bandgap reference (1).
// - Bit 5 flag sets on selected compare event and stays until cleared.
// - Writing one to the flag clears it; writing zero leaves it.
// - With bit 4 set, interrupt request follows the event flag.
// - Read-only bit 3 shows live output, zero while module disabled.
// - Bit 2 set drives comparator output onto the digital output pin.
// - Bits 1:0 pick falling (00,10), rising (01) or either edge (11).
// - Output high when non-inverting input exceeds inverting; edges use this level.
// - Module enabled before wait keeps comparing; its interrupt ends wait.
// - Shallow stop keeps comparing, pin output, flagging and wake-up.
// - Leaving shallow stop by reset returns the module to reset state.
// - Deep stop powers module down; control register returns to reset values, routing bit is kept.
// - Debug halt leaves comparing and flagging exactly as in run.
// - Routing bit sends output to timer channel 0, disconnecting its pin.
module ccl_comparator_ctrl
   import ccl_pkg::*;
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparator interface
   input wire logic comparator_raw_out,
   output logic voltage_comparator_enable,
   output logic reference_input_select,
   // Output pin
   output logic comparator_output_pin,
   output logic comparator_output_pin_oe,
   // Timer capture channel 0 routing
   input wire logic timer_channel_zero_pin,
   output logic timer_capture_in,
   // System mode and interrupt
   input wire logic [1:0] power_mode,
   input wire logic debug_halt,
   output logic compare_irq,
   output logic wake_request
);
   import ccl_pkg::*;

   typedef struct packed {
      logic enable;
      logic refsel;
      logic flag;
      logic irqen;
      logic pinen;
      logic [1:0] mode;
      logic route;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic pin;
      logic pin_oe;
      logic tsync1;
      logic tsync2;
      logic cap;
      logic irq;
      logic wake;
      logic ana_en;
      logic ana_ref;
   } ccl_state_t;

   ccl_state_t st_reg;
   ccl_state_t st_next;
   ccl_edge_if eif ();
   logic active;
   logic deep_stop;
   logic setup;
   logic wr_acc;

   function automatic logic ccl_addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a[7:2] == ofs[7:2];
   endfunction : ccl_addr_hit

   function automatic logic [7:0] ccl_ctrl_image(input ccl_state_t s, input logic lvl);
      logic [7:0] v;
      v = 8'h00;
      v[CCL_BIT_ENABLE] = s.enable;
      v[CCL_BIT_REFSEL] = s.refsel;
      v[CCL_BIT_FLAG] = s.flag;
      v[CCL_BIT_IRQEN] = s.irqen;
      v[CCL_BIT_OUTLVL] = lvl;
      v[CCL_BIT_PINEN] = s.pinen;
      v[CCL_BIT_MODE_HI:CCL_BIT_MODE_LO] = s.mode;
      return v;
   endfunction : ccl_ctrl_image

   // Run, wait, shallow stop and debug halt all keep comparing
   assign deep_stop = ccl_pwr_t'(power_mode) == CCL_PWR_STOP_DEEP;
   assign active = st_reg.enable && !deep_stop;

   assign eif.active = active;
   assign eif.mode = st_reg.mode;
   // Analog output is already high when non-inverting exceeds inverting
   assign eif.raw_level = comparator_raw_out;

   ccl_edge_detect u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .eif(eif.det)
   );

   // Setup cycle answers with zero wait in the following access cycle
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && st_reg.ready;

   always_comb begin
      st_next = st_reg;
      st_next.ready = setup;
      st_next.slverr = 1'b0;
      if (setup) begin
         st_next.rdata = 32'h0000_0000;
         if (ccl_addr_hit(paddr, CCL_OFS_CTRL)) begin
            st_next.rdata[7:0] = ccl_ctrl_image(st_reg, eif.level);
         end else if (ccl_addr_hit(paddr, CCL_OFS_SYSOPT)) begin
            st_next.rdata[CCL_BIT_ROUTE] = st_reg.route;
         end else if (ccl_addr_hit(paddr, CCL_OFS_STATE)) begin
            st_next.rdata[1:0] = power_mode;
            st_next.rdata[2] = debug_halt;
         end else begin
            st_next.slverr = 1'b1;
         end
      end
      if (wr_acc && ccl_addr_hit(paddr, CCL_OFS_CTRL)) begin
         st_next.enable = pwdata[CCL_BIT_ENABLE];
         st_next.refsel = pwdata[CCL_BIT_REFSEL];
         st_next.irqen = pwdata[CCL_BIT_IRQEN];
         st_next.pinen = pwdata[CCL_BIT_PINEN];
         st_next.mode = pwdata[CCL_BIT_MODE_HI:CCL_BIT_MODE_LO];
         if (pwdata[CCL_BIT_FLAG]) begin
            st_next.flag = 1'b0;
         end
      end
      if (wr_acc && ccl_addr_hit(paddr, CCL_OFS_SYSOPT)) begin
         st_next.route = pwdata[CCL_BIT_ROUTE];
      end
      // A new event beats a simultaneous clear
      if (eif.event_pulse) begin
         st_next.flag = 1'b1;
      end
      // Deep stop loses the control register state; route is kept
      if (deep_stop) begin
         st_next.enable = 1'b0;
         st_next.refsel = 1'b0;
         st_next.flag = 1'b0;
         st_next.irqen = 1'b0;
         st_next.pinen = 1'b0;
         st_next.mode = CCL_CTRL_RST[1:0];
      end
      st_next.pin = active && st_reg.pinen && eif.level;
      st_next.pin_oe = active && st_reg.pinen;
      st_next.tsync1 = timer_channel_zero_pin;
      st_next.tsync2 = st_reg.tsync1;
      st_next.cap = st_reg.route ? eif.level : st_reg.tsync2;
      st_next.irq = st_reg.irqen && st_reg.flag;
      st_next.wake = st_reg.irqen && st_reg.flag && power_mode != 2'(CCL_PWR_RUN);
      st_next.ana_en = active;
      st_next.ana_ref = st_reg.refsel;
   end

   // Any reset, including one ending shallow stop, restores defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.slverr;
   assign comparator_output_pin = st_reg.pin;
   assign comparator_output_pin_oe = st_reg.pin_oe;
   assign timer_capture_in = st_reg.cap;
   assign compare_irq = st_reg.irq;
   assign wake_request = st_reg.wake;
   assign voltage_comparator_enable = st_reg.ana_en;
   assign reference_input_select = st_reg.ana_ref;

   a_flag_on_event: assert property (
      @(posedge pclk) disable iff (!presetn)
      eif.event_pulse && !deep_stop |=> st_reg.flag)
      else $error("event did not set flag");
   a_flag_w1c: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && ccl_addr_hit(paddr, CCL_OFS_CTRL) && pwdata[CCL_BIT_FLAG]
      && !eif.event_pulse |=> !st_reg.flag)
      else $error("write one did not clear flag");
   a_flag_w0_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_acc && !pwdata[CCL_BIT_FLAG] && st_reg.flag && !deep_stop |=> st_reg.flag)
      else $error("write zero changed flag");
   a_irq_follows: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_reg.irqen && st_reg.flag |=> compare_irq)
      else $error("interrupt not raised");
   a_irq_gated: assert property (
      @(posedge pclk) disable iff (!presetn)
      !st_reg.irqen |=> !compare_irq)
      else $error("interrupt raised while disabled");
   a_level_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      !active |=> !eif.level)
      else $error("output level not zero while disabled");
   a_pin_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !st_reg.pinen |=> !comparator_output_pin_oe && !comparator_output_pin)
      else $error("pin driven while disabled");
   a_pin_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      active && st_reg.pinen |=> comparator_output_pin == $past(eif.level))
      else $error("pin does not follow output level");
   // Two sync stages plus the level stage: visible on the fourth sample
   a_sync_delay: assert property (
      @(posedge pclk) disable iff (!presetn)
      active && $stable(active) && comparator_raw_out ##1 active ##1 active
      |=> eif.level)
      else $error("synchroniser latency wrong");
   a_route_cap: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_reg.route |=> timer_capture_in == $past(eif.level))
      else $error("capture not routed");
   a_deep_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      deep_stop |=> !st_reg.enable && !st_reg.flag)
      else $error("deep stop kept state");
   a_wake_run: assert property (
      @(posedge pclk) disable iff (!presetn)
      power_mode == 2'(CCL_PWR_RUN) |=> !wake_request)
      else $error("wake raised in run mode");
   a_ref_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_reg.refsel |=> reference_input_select)
      else $error("reference select not presented");
   a_enable_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      active |=> voltage_comparator_enable)
      else $error("comparator not enabled");

   c_flag_set: cover property (@(posedge pclk) disable iff (!presetn)
      !st_reg.flag ##1 st_reg.flag);
   c_irq_wake: cover property (@(posedge pclk) disable iff (!presetn) wake_request);
   c_both_edges: cover property (@(posedge pclk) disable iff (!presetn)
      st_reg.mode == CCL_MODE_BOTH && eif.event_pulse);
   c_route: cover property (@(posedge pclk) disable iff (!presetn) st_reg.route && eif.level);
   c_pin_drive: cover property (@(posedge pclk) disable iff (!presetn)
      comparator_output_pin_oe && comparator_output_pin);
endmodule : ccl_comparator_ctrl

// >>> ccl_analog_model.sv
`timescale 1ns/10ps
module ccl_analog_model #(
   parameter logic [11:0] BANDGAP_MV = 12'h4b0
) (
   // Controls from the block
   input wire logic enable,
   input wire logic ref_select,
   // Bandgap buffer from power management; reference is absent while off
   input wire logic bandgap_on,
   // Pin voltages in millivolts
   input wire logic [11:0] noninv_mv,
   input wire logic [11:0] inv_mv,
   // Raw comparator result
   output logic raw_out
);
   logic [11:0] plus_mv;
   always_comb begin
      plus_mv = ref_select ? (bandgap_on ? BANDGAP_MV : 12'h000) : noninv_mv;
      raw_out = enable && (plus_mv > inv_mv);
   end
endmodule : ccl_analog_model

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
   import ccl_pkg::*;
   localparam logic [7:0] EN = 8'h80, REF = 8'h40, FLG = 8'h20, IRQ = 8'h10, PIN = 8'h04;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, raw, cmp_en, ref_sel, pin, pin_oe, tmr_cap, irq, wake;
   logic tmr_pin = 1'b0, debug_halt = 1'b0, bandgap_buffer_enable = 1'b0;
   logic [1:0] power_mode = 2'h0;
   logic [11:0] noninv_mv = 12'h100, inv_mv = 12'h200;
   int bad_count = 0, n_compared = 0, cycles = 0;

   always #50 pclk = ~pclk;

   ccl_comparator_ctrl u_ccl_comparator_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .comparator_raw_out(raw),
      .voltage_comparator_enable(cmp_en), .reference_input_select(ref_sel),
      .comparator_output_pin(pin), .comparator_output_pin_oe(pin_oe),
      .timer_channel_zero_pin(tmr_pin), .timer_capture_in(tmr_cap), .power_mode(power_mode),
      .debug_halt(debug_halt), .compare_irq(irq), .wake_request(wake));

   ccl_analog_model u_ccl_analog_model (.enable(cmp_en), .ref_select(ref_sel),
      .bandgap_on(bandgap_buffer_enable),
      .noninv_mv(noninv_mv), .inv_mv(inv_mv), .raw_out(raw));

   task wrap_up;
      if (bad_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         wrap_up();
      end
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One APB transfer; holds the request until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // New pin voltages, then time for sync, flag and interrupt to land
   task drive_in(input logic [11:0] p, input logic [11:0] m);
      @(posedge pclk);
      noninv_mv <= p;
      inv_mv <= m;
      repeat (6) @(posedge pclk);
   endtask : drive_in

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CCL_OFS_CTRL, 8'h00); check("ctrl reset", rd, 32'h0);
      apb(0, CCL_OFS_SYSOPT, 8'h00); check("route reset", rd, 32'h0);
      apb(1, 8'h0c, 8'hff); check("unmapped err", 32'(err), 32'h1);
      apb(0, CCL_OFS_CTRL, 8'h00); check("ctrl after unmapped", rd, 32'h0);
      for (int m = 0; m < 4; m++) begin
         drive_in(12'h100, 12'h200);
         apb(1, CCL_OFS_CTRL, EN | IRQ | FLG | 8'(m));
         apb(0, CCL_OFS_CTRL, 8'h00); check("flag cleared", 32'(rd[5]), 32'h0);
         drive_in(12'h300, 12'h200);
         apb(0, CCL_OFS_CTRL, 8'h00);
         check("rise flag", 32'(rd[5]), 32'(m == 1 || m == 3));
         check("level high", 32'(rd[3]), 32'h1);
         check("irq", 32'(irq), 32'(m == 1 || m == 3));
         apb(1, CCL_OFS_CTRL, EN | IRQ | FLG | 8'(m));
         drive_in(12'h100, 12'h200);
         apb(0, CCL_OFS_CTRL, 8'h00); check("fall flag", 32'(rd[5]), 32'(m != 1));
      end
      apb(1, CCL_OFS_CTRL, EN | IRQ | 8'h03);
      apb(0, CCL_OFS_CTRL, 8'h00); check("flag sticky", 32'(rd[5]), 32'h1);
      apb(1, CCL_OFS_CTRL, EN | 8'h03);
      repeat (2) @(posedge pclk);
      check("irq masked", 32'(irq), 32'h0);
      apb(1, CCL_OFS_CTRL, FLG);
      drive_in(12'h300, 12'h200);
      apb(0, CCL_OFS_CTRL, 8'h00); check("level off", rd, 32'h0);
      check("module off", 32'(cmp_en), 32'h0);
      apb(1, CCL_OFS_CTRL, EN | PIN);
      repeat (7) @(posedge pclk);
      check("pin high", {30'h0, pin_oe, pin}, 32'h3);
      apb(1, CCL_OFS_CTRL, EN);
      repeat (2) @(posedge pclk);
      check("pin off", 32'(pin_oe), 32'h0);
      bandgap_buffer_enable <= 1'b1;
      drive_in(12'h000, 12'h300);
      apb(1, CCL_OFS_CTRL, EN | REF);
      repeat (5) @(posedge pclk);
      apb(0, CCL_OFS_CTRL, 8'h00); check("bandgap level", 32'(rd[3]), 32'h1);
      check("ref select out", 32'(ref_sel), 32'h1);
      apb(1, CCL_OFS_SYSOPT, 8'h01);
      repeat (2) @(posedge pclk);
      check("capture routed", 32'(tmr_cap), 32'h1);
      tmr_pin <= 1'b1;
      drive_in(12'h000, 12'hfff);
      check("capture pin cut", 32'(tmr_cap), 32'h0);
      apb(1, CCL_OFS_SYSOPT, 8'h00);
      repeat (4) @(posedge pclk);
      check("capture pin", 32'(tmr_cap), 32'h1);
      for (int p = 0; p < 3; p++) begin
         debug_halt <= (p == 0);
         power_mode <= 2'(p);
         apb(1, CCL_OFS_CTRL, EN | IRQ | FLG | 8'h03);
         drive_in(12'h300, 12'h100);
         apb(0, CCL_OFS_CTRL, 8'h00);
         check("mode flag", 32'(rd[5]), 32'h1);
         check("wake", 32'(wake), 32'(p != 0));
         apb(0, CCL_OFS_STATE, 8'h00);
         check("mode state", rd, {29'h0, (p == 0), 2'(p)});
         drive_in(12'h100, 12'h300);
      end
      apb(1, CCL_OFS_CTRL, EN | PIN);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      power_mode <= 2'h0;
      apb(0, CCL_OFS_CTRL, 8'h00); check("reset from stop", rd, 32'h0);
      apb(1, CCL_OFS_CTRL, EN | IRQ | PIN);
      power_mode <= 2'h3;
      repeat (3) @(posedge pclk);
      power_mode <= 2'h0;
      apb(0, CCL_OFS_CTRL, 8'h00); check("deep stop", rd, 32'h0);
      wrap_up();
   end
endmodule : testbench
